// file: apds_pkg.sv
package apds_pkg;
  // ------------------------------------------------------------
  // Serial frame counts
  // ------------------------------------------------------------
  localparam logic [4:0] APDS_PD_FIRST_EDGE = 5'h02;
  localparam logic [4:0] APDS_PD_LAST_EDGE = 5'h09;
  localparam logic [4:0] APDS_KEEP_EDGE = 5'h0A;
  localparam logic [4:0] APDS_FRAME_EDGES = 5'h10;
  localparam logic [4:0] APDS_LEAD_ZEROS = 5'h04;
  localparam int APDS_DATA_BITS = 12;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int APDS_CLK_PERIOD_PS = 25000;
  localparam int APDS_POWERUP_TIME_NS = 1000;
  localparam int APDS_POWERUP_CYCLES =
    (APDS_POWERUP_TIME_NS * 1000 + APDS_CLK_PERIOD_PS - 1) / APDS_CLK_PERIOD_PS;
  localparam logic [6:0] APDS_POWERUP_CNT = 7'(APDS_POWERUP_CYCLES);
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic APDS_PWR_RESET = 1'b1;
  typedef enum logic [2:0] {
    APDS_IDLE = 3'b001,
    APDS_CONV = 3'b010,
    APDS_WAKE = 3'b100
  } apds_state_t;
endpackage

// file: apds_sync.sv
`timescale 1ns/10ps
module apds_sync
  import apds_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Idle level high keeps a released select from looking like a frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// file: apds_seq.sv
`timescale 1ns/10ps
module apds_seq
  import apds_pkg::*;
#(
  parameter int DATA_BITS = APDS_DATA_BITS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic frame_sel_b,
  input wire logic sclk,
  output logic serial_result_out,
  output logic serial_result_oe,
  // Converter core
  input wire logic [DATA_BITS-1:0] conv_data,
  output logic sample_now,
  output logic analog_on,
  output logic track_mode,
  output logic ready,
  output logic dummy_result
);
  logic sel_s;
  logic sclk_s;

  apds_sync u_sel (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in(frame_sel_b),
    .sync_out(sel_s)
  );

  apds_sync u_sclk (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in(sclk),
    .sync_out(sclk_s)
  );

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  logic sel_p_q, sel_p_d, sclk_p_q, sclk_p_d;
  logic sel_fall, sel_rise, sclk_fall, sclk_any;

  always_comb begin
    sel_p_d = sel_s;
    sclk_p_d = sclk_s;
    sel_fall = sel_p_q & ~sel_s;
    sel_rise = ~sel_p_q & sel_s;
    sclk_fall = sclk_p_q & ~sclk_s;
    sclk_any = sclk_p_q ^ sclk_s;
  end

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  apds_state_t st_q, st_d;
  logic [4:0] edge_q, edge_d;
  logic pwr_dn_q, pwr_dn_d;
  logic waking_q, waking_d;
  logic [6:0] up_cnt_q, up_cnt_d;
  logic dummy_q, dummy_d;
  logic [15:0] shift_q, shift_d;
  logic out_q, out_d;
  logic oe_q, oe_d;
  logic samp_q, samp_d;
  logic on_q, on_d;
  logic trk_q, trk_d;
  logic rdy_q, rdy_d;
  logic [15:0] word_w;

  always_comb begin
    st_d = st_q;
    edge_d = edge_q;
    pwr_dn_d = pwr_dn_q;
    waking_d = waking_q;
    up_cnt_d = up_cnt_q;
    dummy_d = dummy_q;
    shift_d = shift_q;
    out_d = out_q;
    oe_d = oe_q;
    samp_d = 1'b0;
    trk_d = trk_q;
    // First bit stands from select fall, so fall 15 brings the last data bit
    word_w = {APDS_LEAD_ZEROS'(0), conv_data} << (16 - APDS_LEAD_ZEROS - DATA_BITS);
    case (st_q)
      APDS_IDLE: begin
        if (sel_fall) begin
          edge_d = 5'h00;
          samp_d = ~pwr_dn_q;
          out_d = word_w[15];
          shift_d = {word_w[14:0], 1'b0};
          oe_d = 1'b1;
          dummy_d = pwr_dn_q;
          if (pwr_dn_q) begin
            waking_d = 1'b1;
            st_d = APDS_WAKE;
          end else begin
            trk_d = 1'b0;
            st_d = APDS_CONV;
          end
        end
      end
      APDS_CONV, APDS_WAKE: begin
        if (st_q == APDS_WAKE && sclk_any && !trk_q) begin
          trk_d = 1'b1;
        end
        if (sclk_fall && edge_q != 5'h1F) begin
          edge_d = edge_q + 5'h01;
          if (oe_q) begin
            out_d = shift_q[15];
            shift_d = {shift_q[14:0], 1'b0};
          end
          if (edge_q + 5'h01 == APDS_FRAME_EDGES) begin
            oe_d = 1'b0;
          end
          if (edge_q == 5'h0C && st_q == APDS_CONV) begin
            trk_d = 1'b1;
          end
        end
        if (sel_rise) begin
          oe_d = 1'b0;
          st_d = APDS_IDLE;
          if (st_q == APDS_WAKE) begin
            if (edge_q < APDS_KEEP_EDGE) begin
              pwr_dn_d = 1'b1;
              trk_d = 1'b0;
            end else begin
              pwr_dn_d = 1'b0;
            end
            waking_d = 1'b0;
          end else if (edge_q >= APDS_PD_FIRST_EDGE && edge_q <= APDS_PD_LAST_EDGE) begin
            pwr_dn_d = 1'b1;
            oe_d = 1'b0;
            trk_d = 1'b0;
          end else begin
            trk_d = 1'b1;
          end
        end
      end
      default: begin
        st_d = APDS_IDLE;
      end
    endcase
    // Power-up delay runs from select fall of a wake frame
    if (pwr_dn_d && !waking_d) begin
      up_cnt_d = 7'h00;
    end else if (up_cnt_q != APDS_POWERUP_CNT) begin
      up_cnt_d = up_cnt_q + 7'h01;
    end
    on_d = ~pwr_dn_d | waking_d;
    rdy_d = on_d && (up_cnt_d == APDS_POWERUP_CNT);
  end

  // Supply start taken as normal mode with track on; host dummy fixes it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_p_q <= 1'b1;
      // Serial clock idles high; a low value here would fake an edge
      sclk_p_q <= 1'b1;
      st_q <= APDS_IDLE;
      edge_q <= 5'h00;
      pwr_dn_q <= ~APDS_PWR_RESET;
      waking_q <= 1'b0;
      up_cnt_q <= 7'h00;
      dummy_q <= 1'b0;
      shift_q <= 16'h0000;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      samp_q <= 1'b0;
      on_q <= 1'b1;
      trk_q <= 1'b1;
      rdy_q <= 1'b0;
    end else begin
      sel_p_q <= sel_p_d;
      sclk_p_q <= sclk_p_d;
      st_q <= st_d;
      edge_q <= edge_d;
      pwr_dn_q <= pwr_dn_d;
      waking_q <= waking_d;
      up_cnt_q <= up_cnt_d;
      dummy_q <= dummy_d;
      shift_q <= shift_d;
      out_q <= out_d;
      oe_q <= oe_d;
      samp_q <= samp_d;
      on_q <= on_d;
      trk_q <= trk_d;
      rdy_q <= rdy_d;
    end
  end

  assign serial_result_out = out_q;
  assign serial_result_oe = oe_q;
  assign sample_now = samp_q;
  assign analog_on = on_q;
  assign track_mode = trk_q;
  assign ready = rdy_q;
  assign dummy_result = dummy_q;
endmodule

// file: apds_host.sv
`timescale 1ns/10ps
module apds_host (
  // Link pins
  output logic frame_sel_b,
  output logic sclk,
  input wire logic serial_result_out
);
  // Clock stands high outside frames
  initial begin
    frame_sel_b = 1'b1;
    sclk = 1'b1;
  end
  // n falling edges; a bit is taken just before each of the first 16 falls
  task automatic frame(input int n, output logic [15:0] bits);
    bits = 16'h0000;
    frame_sel_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      #90;
      if (i < 16) bits[15-i] = serial_result_out;
      #10 sclk = 1'b0;
      #100 sclk = 1'b1;
    end
    #100 frame_sel_b = 1'b1;
    #1000;
  endtask
endmodule

// file: apds_seq_chk.sv
`timescale 1ns/10ps
module apds_seq_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Watched ports
  input wire logic frame_sel_b,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic sample_now,
  input wire logic analog_on,
  input wire logic track_mode,
  input wire logic ready
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Pin edges pass a two-flop synchroniser, hence the slack in the windows
  sequence s_wake;
    $fell(frame_sel_b) && !analog_on;
  endsequence
  sequence s_idle;
    frame_sel_b [*8];
  endsequence
  property p_pd; !analog_on |-> !track_mode && !ready; endproperty
  a_pd: assert property (p_pd) else $error("pd hold");
  property p_rel; s_idle |-> !serial_result_oe; endproperty
  a_rel: assert property (p_rel) else $error("oe held");
  property p_state; $fell(analog_on) |-> frame_sel_b; endproperty
  a_state: assert property (p_state) else $error("pd off rise");
  property p_wake; s_wake |-> ##[2:8] analog_on; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_trk; s_wake |-> !track_mode [*3] ##[1:12] track_mode; endproperty
  a_trk: assert property (p_trk) else $error("track");
  property p_rdy; $rose(ready) |-> $past(analog_on, 36); endproperty
  a_rdy: assert property (p_rdy) else $error("ready early");
  property p_lead; $rose(serial_result_oe) |-> !serial_result_out [*3]; endproperty
  a_lead: assert property (p_lead) else $error("lead");
  property p_smp; sample_now |-> analog_on && !frame_sel_b; endproperty
  a_smp: assert property (p_smp) else $error("sample");
endmodule

// file: test_apds_seq.sv
`timescale 1ns/10ps
module test_apds_seq;
  logic mclk, rst_b, frame_sel_b, sclk, serial_result_out, serial_result_oe;
  logic sample_now, analog_on, track_mode, ready, dummy_result;
  logic [11:0] conv_data;
  logic [15:0] bits;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'ha07d;
  int n;
  apds_seq u_dut (
    .mclk(mclk), .rst_b(rst_b), .frame_sel_b(frame_sel_b), .sclk(sclk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .conv_data(conv_data), .sample_now(sample_now), .analog_on(analog_on),
    .track_mode(track_mode), .ready(ready), .dummy_result(dummy_result)
  );
  apds_host u_host (
    .frame_sel_b(frame_sel_b), .sclk(sclk), .serial_result_out(serial_result_out)
  );
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [15:0] stream(input logic [11:0] d);
    return {4'h0, d};
  endfunction
  function automatic logic pd(input int k);
    return k >= 2 && k < 10;
  endfunction
  // Full frame; a dummy frame's bits are not worth comparing
  task automatic data_frame(input logic dum);
    @(posedge mclk);
    #2 conv_data = 12'($random(seed));
    u_host.frame(16, bits);
    if (!dum) check("stream", bits, stream(conv_data));
    check("oe", serial_result_oe, 1'b0);
    check("dummy", dummy_result, dum);
    check("track", track_mode, 1'b1);
  endtask
  initial begin
    #600000;
    n_fail++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    conv_data = 12'h000;
    repeat (12) @(posedge mclk);
    #2 rst_b = 1'b1;
    repeat (2) @(posedge mclk);
    data_frame(1'b0);
    for (int i = 0; i < 18; i++) begin
      n = (i < 12) ? i : $unsigned($random(seed)) % 12;
      u_host.frame(n, bits);
      check("power", analog_on, !pd(n));
      check("oe_abort", serial_result_oe, 1'b0);
      if (pd(n)) begin
        check("hold", track_mode, 1'b0);
        u_host.frame(11 - n, bits);
        check("stay_down", analog_on, 1'b0);
        data_frame(1'b1);
        check("ready", ready, 1'b1);
        data_frame(1'b0);
      end
    end
    // Reset in power-down must bring back normal mode with track on
    u_host.frame(3, bits);
    check("pd_pre", analog_on, 1'b0);
    @(posedge mclk);
    #2 rst_b = 1'b0;
    repeat (4) @(posedge mclk);
    #2 rst_b = 1'b1;
    check("rst_on", analog_on, 1'b1);
    check("rst_trk", track_mode, 1'b1);
    check("rst_rdy", ready, 1'b0);
    repeat (2) @(posedge mclk);
    data_frame(1'b0);
    check("rst_rdy_up", ready, 1'b1);
    complete_run();
  end
endmodule
bind apds_seq apds_seq_chk u_chk (
  .mclk(mclk), .rst_b(rst_b), .frame_sel_b(frame_sel_b),
  .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
  .sample_now(sample_now), .analog_on(analog_on), .track_mode(track_mode), .ready(ready)
);
